// File: hdl/mhp_cfg.svh
// Constants of the host port attachment: offsets, field positions, reset values.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef MHP_CFG_SVH
`define MHP_CFG_SVH

// Host side geometry
`define MHP_BUF_AW        21
`define MHP_REG_WORDS     32
`define MHP_REG_IW        5
`define MHP_PROTO_GENERIC 3'h3

// Strap field positions
`define MHP_STRAP_WIDTH   0
`define MHP_STRAP_PROTO_L 1
`define MHP_STRAP_PROTO_H 3
`define MHP_STRAP_ORDER   4
`define MHP_STRAP_WAIT    5

// Register bus map
`define MHP_AXI_AW        8
`define MHP_CTRL_OFS      8'h00
`define MHP_STAT_OFS      8'h04
`define MHP_CTRL_EN_BIT   0
`define MHP_CTRL_RST      1'h1
`define MHP_STAT_GEN_BIT  16
`define MHP_STAT_BUSY_BIT 17
`define MHP_STAT_BS_BIT   18
`define MHP_STAT_DONE_BIT 19

// Bus answers
`define MHP_RESP_OKAY     2'h0
`define MHP_RESP_SLVERR   2'h2

`endif

// File: hdl/mhp_pkg.sv
// Types shared by the host port attachment.
// Assumes mhp_cfg.svh sits beside it.
`include "mhp_cfg.svh"

package mhp_pkg;
   // Host transfer sequencer states
   typedef enum logic [1:0] {
      MHP_IDLE,
      MHP_MEM,
      MHP_HOLD
   } mhp_state_t;
endpackage

// File: hdl/mhp_sync.sv
// Two flip-flop synchroniser, one stage pair per bit.
// Assumes inputs may change at any time relative to clk.
`timescale 1ns/1ps
`default_nettype none

module mhp_sync #(
   parameter int           W   = 1,
   parameter logic [W-1:0] RST = '0
) (
   // System
   input  wire logic         clk,
   input  wire logic         rstn,
   // Data
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_ff;

   // Per-bit stage pair; first stage feeds only the second
   genvar i;
   generate
      for (i = 0; i < W; i++)
      begin : g_bit
         always_ff @(posedge clk or negedge rstn)
         begin
            if (!rstn)
            begin
               meta_ff[i] <= RST[i];
               q[i]       <= RST[i];
            end
            else
            begin
               meta_ff[i] <= d[i];
               q[i]       <= meta_ff[i];
            end
         end
      end
   endgenerate
endmodule // mhp_sync

`default_nettype wire

// File: hdl/mhp_decode.sv
// Host address decode into register file index and display buffer address.
// Assumes the host glue presents a latched, demultiplexed address.
`timescale 1ns/1ps
`default_nettype none
`include "mhp_cfg.svh"

module mhp_decode (
   // Host address
   input  wire logic                    memory_register_select,
   input  wire logic [`MHP_BUF_AW-1:0]  host_addr,
   // Decoded
   output logic                         is_reg,
   output logic [`MHP_REG_IW-1:0]       reg_idx,
   output logic [`MHP_BUF_AW-1:0]       buf_addr
);
   // Low select is register space, high is the display buffer
   assign is_reg   = ~memory_register_select;
   // Only five address bits, 5 to 1, index the register file, so it repeats every 64 bytes
   assign reg_idx  = host_addr[`MHP_REG_IW:1];
   // Full 2M byte word address; bits above are not seen, so images repeat
   assign buf_addr = {host_addr[`MHP_BUF_AW-1:1], 1'b0};
endmodule // mhp_decode

`default_nettype wire

// File: hdl/mhp_host_port.sv
// Generic asynchronous host port with register file, display buffer port and AXI4-Lite control.
// Assumes host glue demultiplexes the address and holds it stable through each strobe.
//
// The AXI4-Lite interface to the registers and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "mhp_cfg.svh"

module mhp_host_port (
   // System
   input  wire logic                    clk,
   input  wire logic                    rstn,
   // Configuration straps
   input  wire logic [15:0]             config_strap_pins,
   // Host port
   input  wire logic                    host_cs_n,
   input  wire logic                    memory_register_select,
   input  wire logic [`MHP_BUF_AW-1:0]  host_addr,
   input  wire logic                    low_byte_write_strobe_n,
   input  wire logic                    high_byte_write_strobe_n,
   input  wire logic                    host_low_read_strobe_n,
   input  wire logic                    host_high_read_strobe_n,
   input  wire logic                    bus_start_strobe_n,
   input  wire logic [15:0]             host_data_in,
   output logic      [15:0]             host_data_out,
   output logic                         host_data_oe,
   output logic                         wait_request,
   // Display buffer port
   output logic                         mem_req,
   output logic                         mem_we,
   output logic      [1:0]              mem_be,
   output logic      [`MHP_BUF_AW-1:0]  mem_addr,
   output logic      [15:0]             mem_wdata,
   input  wire logic                    mem_ack,
   input  wire logic [15:0]             mem_rdata,
   // AXI4-Lite write
   input  wire logic [`MHP_AXI_AW-1:0]  s_axi_awaddr,
   input  wire logic                    s_axi_awvalid,
   output logic                         s_axi_awready,
   input  wire logic [31:0]             s_axi_wdata,
   input  wire logic [3:0]              s_axi_wstrb,
   input  wire logic                    s_axi_wvalid,
   output logic                         s_axi_wready,
   output logic      [1:0]              s_axi_bresp,
   output logic                         s_axi_bvalid,
   input  wire logic                    s_axi_bready,
   // AXI4-Lite read
   input  wire logic [`MHP_AXI_AW-1:0]  s_axi_araddr,
   input  wire logic                    s_axi_arvalid,
   output logic                         s_axi_arready,
   output logic      [31:0]             s_axi_rdata,
   output logic      [1:0]              s_axi_rresp,
   output logic                         s_axi_rvalid,
   input  wire logic                    s_axi_rready
);
   import mhp_pkg::*;

   mhp_state_t                 state_ff;
   mhp_state_t                 nxt_state;
   logic [15:0]                strap_ff;
   logic [5:0]                 strb_q;
   logic [`MHP_REG_IW-1:0]     reg_idx;
   logic [`MHP_BUF_AW-1:0]     buf_addr;
   logic [15:0]                regf_ff [`MHP_REG_WORDS];
   logic [1:0]                 acc_be;
   logic [15:0]                acc_wd;
   logic [15:0]                rd_word;
   logic [`MHP_AXI_AW-1:0]     aw_addr_ff;
   logic [31:0]                w_data_ff;
   logic [3:0]                 w_strb_ff;
   logic [31:0]                status;
   logic                       strap_done_ff, ctrl_en_ff, acc_a0_ff, acc_rd_ff, aw_got_ff, w_got_ff;
   logic                       is_reg, cs, wr, rd, narrow, little, wait_hi, generic, port_on, rd_a0;
   logic                       take, done_reg, done_mem, rel, aw_hs, w_hs, ar_hs, commit;
   logic                       nxt_aw_got, nxt_w_got, nxt_bvalid, nxt_rvalid;

   // Strobes are synchronised before any use; inactive level is high
   mhp_sync #(
      .W   (6),
      .RST (6'h3F)
   ) u_sync (
      .clk  (clk),
      .rstn (rstn),
      .d    ({bus_start_strobe_n, host_cs_n, high_byte_write_strobe_n,
              low_byte_write_strobe_n, host_high_read_strobe_n, host_low_read_strobe_n}),
      .q    (strb_q)
   );

   // Address split into register index and buffer address
   mhp_decode u_decode (
      .memory_register_select (memory_register_select),
      .host_addr              (host_addr),
      .is_reg                 (is_reg),
      .reg_idx                (reg_idx),
      .buf_addr               (buf_addr)
   );

   // Straps caught on the first edge after reset release
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         strap_ff      <= 16'h0000;
         strap_done_ff <= 1'b0;
      end
      else if (!strap_done_ff)
      begin
         strap_ff      <= config_strap_pins;
         strap_done_ff <= 1'b1;
      end
   end

   // Strap fields
   assign narrow  = strap_ff[`MHP_STRAP_WIDTH];
   assign little  = strap_ff[`MHP_STRAP_ORDER];
   assign wait_hi = strap_ff[`MHP_STRAP_WAIT];
   assign generic = strap_ff[`MHP_STRAP_PROTO_H:`MHP_STRAP_PROTO_L] == `MHP_PROTO_GENERIC;
   assign port_on = strap_done_ff & generic & ctrl_en_ff;

   // Generic pin functions: two byte write strobes, two byte read strobes
   assign cs = ~strb_q[4];
   assign wr = ~strb_q[2] | ~strb_q[3];
   assign rd = ~strb_q[0] | ~strb_q[1];

   // Byte lanes: 8-bit mode uses the low lane and address bit 0, 16-bit mode may swap lanes
   always_comb
   begin
      acc_be = 2'b00;
      acc_wd = host_data_in;
      if (narrow)
      begin
         acc_be = host_addr[0] ? 2'b10 : 2'b01;
         acc_wd = {host_data_in[7:0], host_data_in[7:0]};
      end
      else if (little)
         acc_be = wr ? ~strb_q[3:2] : ~strb_q[1:0];
      else
      begin
         acc_be = wr ? {~strb_q[2], ~strb_q[3]} : {~strb_q[0], ~strb_q[1]};
         acc_wd = {host_data_in[7:0], host_data_in[15:8]};
      end
   end

   // Sequencer events; address is held by the glue latch while strobes are low
   assign take     = (state_ff == MHP_IDLE) & port_on & cs & (wr | rd);
   assign done_reg = take & is_reg;
   assign done_mem = (state_ff == MHP_MEM) & mem_ack;
   assign rel      = (state_ff == MHP_HOLD) & ~(cs & (wr | rd));

   // Next sequencer state
   always_comb
   begin
      nxt_state = state_ff;
      unique case (state_ff)
         MHP_IDLE : if (take) nxt_state = is_reg ? MHP_HOLD : MHP_MEM;
         MHP_MEM  : if (done_mem) nxt_state = MHP_HOLD;
         MHP_HOLD : if (rel) nxt_state = MHP_IDLE;
      endcase
   end

   // Sequencer state
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         state_ff <= MHP_IDLE;
      else
         state_ff <= nxt_state;
   end

   // Access attributes kept for the buffer round trip
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         acc_a0_ff <= 1'b0;
         acc_rd_ff <= 1'b0;
      end
      else if (take)
      begin
         acc_a0_ff <= host_addr[0];
         acc_rd_ff <= ~wr;
      end
   end

   // Register file, written with byte enables on a register space write
   genvar gi;
   generate
      for (gi = 0; gi < `MHP_REG_WORDS; gi++)
      begin : g_regf
         always_ff @(posedge clk or negedge rstn)
         begin
            if (!rstn)
               regf_ff[gi] <= 16'h0000;
            else if (done_reg && wr && reg_idx == gi[`MHP_REG_IW-1:0])
            begin
               if (acc_be[0])
                  regf_ff[gi][7:0] <= acc_wd[7:0];
               if (acc_be[1])
                  regf_ff[gi][15:8] <= acc_wd[15:8];
            end
         end
      end
   endgenerate

   // Display buffer request, held until acknowledged
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         mem_req   <= 1'b0;
         mem_we    <= 1'b0;
         mem_be    <= 2'b00;
         mem_addr  <= '0;
         mem_wdata <= 16'h0000;
      end
      else if (take && !is_reg)
      begin
         mem_req   <= 1'b1;
         mem_we    <= wr;
         mem_be    <= acc_be;
         mem_addr  <= buf_addr;
         mem_wdata <= acc_wd;
      end
      else if (done_mem)
         mem_req <= 1'b0;
   end

   // Read word source and the address bit that picks the byte in 8-bit mode
   assign rd_word = done_reg ? regf_ff[reg_idx] : mem_rdata;
   assign rd_a0   = done_reg ? host_addr[0] : acc_a0_ff;

   // Host data drive, from data ready until the strobes release
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         host_data_out <= 16'h0000;
         host_data_oe  <= 1'b0;
      end
      else if ((done_reg && !wr) || (done_mem && acc_rd_ff))
      begin
         host_data_oe <= 1'b1;
         if (narrow)
            host_data_out <= {8'h00, rd_a0 ? rd_word[15:8] : rd_word[7:0]};
         else if (little)
            host_data_out <= rd_word;
         else
            host_data_out <= {rd_word[7:0], rd_word[15:8]};
      end
      else if (rel)
         host_data_oe <= 1'b0;
   end

   // Wait asserted on buffer accesses, from strobe seen until data settled, at the strapped level; never on register accesses
   // Reset drives it low, and the first edge after release drives it high, since strap_ff still reads zero at that edge
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         wait_request <= 1'b0;
      else if ((take && !is_reg) || (state_ff == MHP_MEM && !mem_ack))
         wait_request <= wait_hi;
      else
         wait_request <= ~wait_hi;
   end

   // Register bus handshakes
   assign aw_hs      = s_axi_awvalid & s_axi_awready;
   assign w_hs       = s_axi_wvalid & s_axi_wready;
   assign ar_hs      = s_axi_arvalid & s_axi_arready;
   assign commit     = aw_got_ff & w_got_ff;
   assign nxt_aw_got = (aw_got_ff | aw_hs) & ~commit;
   assign nxt_w_got  = (w_got_ff | w_hs) & ~commit;
   assign nxt_bvalid = commit | (s_axi_bvalid & ~s_axi_bready);
   assign nxt_rvalid = ar_hs | (s_axi_rvalid & ~s_axi_rready);

   // Write address and data capture, in either order
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         aw_got_ff  <= 1'b0;
         w_got_ff   <= 1'b0;
         aw_addr_ff <= '0;
         w_data_ff  <= 32'h0000_0000;
         w_strb_ff  <= 4'h0;
      end
      else
      begin
         aw_got_ff <= nxt_aw_got;
         w_got_ff  <= nxt_w_got;
         if (aw_hs)
            aw_addr_ff <= s_axi_awaddr;
         if (w_hs)
         begin
            w_data_ff <= s_axi_wdata;
            w_strb_ff <= s_axi_wstrb;
         end
      end
   end

   // Write channel ready and response
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= `MHP_RESP_OKAY;
      end
      else
      begin
         s_axi_awready <= ~nxt_aw_got & ~nxt_bvalid;
         s_axi_wready  <= ~nxt_w_got & ~nxt_bvalid;
         s_axi_bvalid  <= nxt_bvalid;
         if (commit)
            s_axi_bresp <= ({aw_addr_ff[`MHP_AXI_AW-1:2], 2'b00} == `MHP_CTRL_OFS ||
                            {aw_addr_ff[`MHP_AXI_AW-1:2], 2'b00} == `MHP_STAT_OFS) ?
                           `MHP_RESP_OKAY : `MHP_RESP_SLVERR;
      end
   end

   // Control register: host port enable
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
         ctrl_en_ff <= `MHP_CTRL_RST;
      else if (commit && w_strb_ff[0] && {aw_addr_ff[`MHP_AXI_AW-1:2], 2'b00} == `MHP_CTRL_OFS)
         ctrl_en_ff <= w_data_ff[`MHP_CTRL_EN_BIT];
   end

   // Status word: straps, mode, activity, bus start level
   always_comb
   begin
      status                     = {16'h0000, strap_ff};
      status[`MHP_STAT_GEN_BIT]  = generic;
      status[`MHP_STAT_BUSY_BIT] = state_ff != MHP_IDLE;
      status[`MHP_STAT_BS_BIT]   = strb_q[5];
      status[`MHP_STAT_DONE_BIT] = strap_done_ff;
   end

   // Read channel
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= `MHP_RESP_OKAY;
      end
      else
      begin
         s_axi_arready <= ~nxt_rvalid;
         s_axi_rvalid  <= nxt_rvalid;
         if (ar_hs)
         begin
            s_axi_rresp <= `MHP_RESP_OKAY;
            if ({s_axi_araddr[`MHP_AXI_AW-1:2], 2'b00} == `MHP_CTRL_OFS)
               s_axi_rdata <= {31'h0000_0000, ctrl_en_ff};
            else if ({s_axi_araddr[`MHP_AXI_AW-1:2], 2'b00} == `MHP_STAT_OFS)
               s_axi_rdata <= status;
            else
            begin
               s_axi_rdata <= 32'h0000_0000;
               s_axi_rresp <= `MHP_RESP_SLVERR;
            end
         end
      end
   end
endmodule // mhp_host_port

`default_nettype wire

// File: testbench/mhp_checker.sv
// Checker for mhp_host_port: buffer requests, wait level, port release, bus answers.
// Assumes it is bound to mhp_host_port and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
`include "mhp_cfg.svh"

module mhp_checker (
   // System
   input wire logic        clk,
   input wire logic        rstn,
   input wire logic [15:0] config_strap_pins,
   // Host port
   input wire logic        host_cs_n,
   input wire logic        low_byte_write_strobe_n,
   input wire logic        high_byte_write_strobe_n,
   input wire logic        host_low_read_strobe_n,
   input wire logic        host_high_read_strobe_n,
   input wire logic        host_data_oe,
   input wire logic        wait_request,
   // Buffer port
   input wire logic        mem_req,
   input wire logic        mem_ack,
   input wire logic [`MHP_BUF_AW-1:0] mem_addr,
   // Register bus
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   logic [1:0]  cnt_ff;
   logic [15:0] strap_ff;

   // Capture straps at the first edge after reset, then mark the port settled
   always_ff @(posedge clk or negedge rstn)
   begin
      if (!rstn)
      begin
         cnt_ff   <= 2'h0;
         strap_ff <= 16'h0000;
      end
      else if (cnt_ff != 2'h3)
      begin
         cnt_ff <= cnt_ff + 2'h1;
         if (cnt_ff == 2'h0) strap_ff <= config_strap_pins;
      end
   end

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   // Host side fully released for five samples
   sequence s_host_idle;
      (host_cs_n && low_byte_write_strobe_n && high_byte_write_strobe_n
       && host_low_read_strobe_n && host_high_read_strobe_n)[*5];
   endsequence
   sequence s_aw_taken;
      s_axi_awvalid && s_axi_awready;
   endsequence

   a_req_hold: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr))
      else $error("buffer request dropped or moved before ack");
   a_req_even: assert property (mem_req |-> !mem_addr[0])
      else $error("buffer request on odd byte address");
   a_wait_level: assert property (cnt_ff == 2'h3 |-> ((wait_request == strap_ff[5]) == mem_req))
      else $error("wait level does not follow buffer request");
   a_port_dead: assert property (cnt_ff == 2'h3 && strap_ff[3:1] != 3'h3 |-> !mem_req && !host_data_oe)
      else $error("host port active under foreign protocol straps");
   a_oe_release: assert property (s_host_idle |-> !host_data_oe)
      else $error("host data still driven after release");
   a_write_resp: assert property (s_aw_taken |=> !s_axi_awready ##[0:2] s_axi_bvalid)
      else $error("write response late");
   a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response withdrawn");
   a_read_resp: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready)
      else $error("read data late");
   a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("read data withdrawn");
endmodule // mhp_checker

bind mhp_host_port mhp_checker chk_u (.clk, .rstn, .config_strap_pins, .host_cs_n, .low_byte_write_strobe_n,
   .high_byte_write_strobe_n, .host_low_read_strobe_n, .host_high_read_strobe_n, .host_data_oe, .wait_request,
   .mem_req, .mem_ack, .mem_addr, .s_axi_awvalid, .s_axi_awready, .s_axi_bvalid, .s_axi_bready,
   .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready);

`default_nettype wire

// File: testbench/mhp_glue_model.sv
// Host glue model: address latch and selects for a multiplexed card-slot bus.
// Assumes the processor drives the address while cpu_ale is high.
`timescale 1ns/1ps
`default_nettype none

module mhp_glue (
   // Processor side
   input  wire logic [25:0] cpu_ad,
   input  wire logic        cpu_ale,
   input  wire logic        slot_sel_n,
   input  wire logic        card_config_space_select_n,
   // Device side
   output logic             memory_register_select,
   output logic [20:0]      host_addr,
   output logic             host_cs_n,
   output logic             bus_start_strobe_n
);
   logic [25:0] adr_ff;

   // Transparent latch demultiplexes the address
   always_latch
   begin
      if (cpu_ale) adr_ff <= cpu_ad;
   end

   // Bit 23 picks the space; other upper bits and config select stay undecoded
   assign memory_register_select = adr_ff[23];
   assign host_addr = adr_ff[20:0];
   assign host_cs_n = slot_sel_n;
   assign bus_start_strobe_n = 1'b1;
endmodule // mhp_glue

`default_nettype wire

// File: testbench/tb.sv
// Testbench for mhp_host_port: straps, aliasing, byte lanes, register bus.
// Assumes mhp_glue sits in front of the host port and a buffer model answers requests.
`timescale 1ns/1ps
`default_nettype none
`include "mhp_cfg.svh"

module tb;
   import mhp_pkg::*;
   logic clk, rstn, cpu_ale, slot_sel_n, cfg_sel_n, memory_register_select, host_cs_n, bus_start_strobe_n;
   logic we0_n, we1_n, rd0_n, rd1_n, host_data_oe, wait_request, mem_req, mem_we, mem_ack, saw_req;
   logic [25:0] cpu_ad;
   logic [20:0] host_addr, mem_addr, last_a;
   logic [15:0] config_strap_pins, host_data_in, host_data_out, mem_wdata, mem_rdata, last_wd, h;
   logic [1:0]  mem_be, last_be, s_axi_bresp, s_axi_rresp, r;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, d;
   logic [3:0]  s_axi_wstrb;
   logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
   logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
   logic [15:0] mem [1024];
   int dly, ack_dly, n_cyc, n_fail, check_count;

   mhp_glue glue_u (.cpu_ad, .cpu_ale, .slot_sel_n, .card_config_space_select_n(cfg_sel_n),
      .memory_register_select, .host_addr, .host_cs_n, .bus_start_strobe_n);
   mhp_host_port dut_u (.clk, .rstn, .config_strap_pins, .host_cs_n, .memory_register_select, .host_addr,
      .low_byte_write_strobe_n(we0_n), .high_byte_write_strobe_n(we1_n), .host_low_read_strobe_n(rd0_n),
      .host_high_read_strobe_n(rd1_n), .bus_start_strobe_n, .host_data_in, .host_data_out, .host_data_oe,
      .wait_request, .mem_req, .mem_we, .mem_be, .mem_addr, .mem_wdata, .mem_ack, .mem_rdata,
      .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
      .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

   always #25 clk = ~clk;

   // Cycle ceiling; running out counts as a mismatch
   always @(posedge clk)
   begin
      n_cyc <= n_cyc + 1;
      if (n_cyc == 20000)
      begin
         n_fail = n_fail + 1;
         end_sim();
      end
   end

   // Display buffer model, folded to 1K words, answering after ack_dly cycles
   always @(posedge clk)
   begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (mem_req && !mem_ack)
      begin
         saw_req <= 1'b1;
         dly <= dly + 1;
         if (dly >= ack_dly)
         begin
            dly <= 0;
            mem_ack <= 1'b1;
            {last_a, last_be, last_wd} <= {mem_addr, mem_be, mem_wdata};
            mem_rdata <= mem[mem_addr[10:1]];
            if (mem_we && mem_be[0]) mem[mem_addr[10:1]][7:0] <= mem_wdata[7:0];
            if (mem_we && mem_be[1]) mem[mem_addr[10:1]][15:8] <= mem_wdata[15:8];
         end
      end
   end

   task automatic chk(input logic [47:0] got, input logic [47:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic t_rst(input logic [15:0] s);
      @(posedge clk);
      rstn <= 1'b0;
      config_strap_pins <= s;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(posedge clk);
   endtask

   task automatic axw(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      {s_axi_awaddr, s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {a, v, 3'b111};
      do
      begin
         @(posedge clk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
      end
      while (!s_axi_bvalid);
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
   endtask

   task automatic axr(input logic [7:0] a);
      @(posedge clk);
      {s_axi_araddr, s_axi_arvalid, s_axi_rready} <= {a, 2'b11};
      do
      begin
         @(posedge clk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
      end
      while (!s_axi_rvalid);
      {d, r} = {s_axi_rdata, s_axi_rresp};
      s_axi_rready <= 1'b0;
   endtask

   // Processor access: latch the address, then strobe until data shows or the hold ends
   task automatic hacc(input logic [31:0] a, input logic wr, input logic [1:0] sb, input logic [15:0] wd);
      h = 16'hDEAD;
      @(posedge clk);
      {cpu_ad, cpu_ale} <= {a[25:0], 1'b1};
      @(posedge clk);
      cpu_ale <= 1'b0;
      @(posedge clk);
      {cpu_ad, slot_sel_n, cfg_sel_n, host_data_in} <= {~a[25:0], 1'b0, a[30], wd};
      if (wr) {we1_n, we0_n} <= ~sb;
      else {rd1_n, rd0_n} <= ~sb;
      for (int i = 0; i < 20; i++)
      begin
         @(posedge clk);
         if (!wr && host_data_oe === 1'b1)
         begin
            h = host_data_out;
            break;
         end
      end
      {we1_n, we0_n, rd1_n, rd0_n, slot_sel_n, cfg_sel_n, host_data_in} <= {6'h3F, ~wd};
      repeat (6) @(posedge clk);
   endtask

   task automatic t_regs;
      axr(`MHP_STAT_OFS);
      chk({d, r}, {32'h000D_0036, `MHP_RESP_OKAY});
      axw(`MHP_STAT_OFS, 32'h0);
      chk(r, `MHP_RESP_OKAY);
      axr(`MHP_CTRL_OFS);
      chk({d, r}, {32'h1, `MHP_RESP_OKAY});
      axw(8'h08, 32'hFFFF_FFFF);
      chk(r, `MHP_RESP_SLVERR);
      axr(8'h08);
      chk({d, r}, {32'h0, `MHP_RESP_SLVERR});
      hacc(32'h6400_0006, 1'b1, 2'h3, 16'hA55A);
      hacc(32'h6400_0046, 1'b0, 2'h3, 16'h0);
      chk(h, 16'hA55A);
      hacc(32'h6500_0006, 1'b0, 2'h3, 16'h0);
      chk(h, 16'hA55A);
      hacc(32'h0900_0006, 1'b0, 2'h3, 16'h0);
      chk(h, 16'hA55A);
      hacc(32'h6400_0008, 1'b0, 2'h3, 16'h0);
      chk(h, 16'h0);
      axw(`MHP_CTRL_OFS, 32'h0);
      hacc(32'h6400_0006, 1'b0, 2'h3, 16'h0);
      chk(h, 16'hDEAD);
      axw(`MHP_CTRL_OFS, 32'h1);
   endtask

   task automatic t_buf;
      hacc(32'h6480_0010, 1'b1, 2'h3, 16'h1234);
      chk({last_a, last_be, last_wd}, {21'h10, 2'h3, 16'h1234});
      ack_dly = 6;
      hacc(32'h64A0_0010, 1'b0, 2'h3, 16'h0);
      chk(h, 16'h1234);
      hacc(32'h6480_0012, 1'b1, 2'h1, 16'hBEEF);
      chk({last_a, last_be, last_wd[7:0]}, {21'h12, 2'h1, 8'hEF});
      hacc(32'h0980_0010, 1'b0, 2'h2, 16'h0);
      chk(h[15:8], 8'h12);
   endtask

   task automatic t_modes;
      t_rst(16'h0006);
      ack_dly = 2;
      hacc(32'h6480_0020, 1'b1, 2'h3, 16'h1234);
      chk({last_be, last_wd}, {2'h3, 16'h3412});
      hacc(32'h6480_0020, 1'b0, 2'h3, 16'h0);
      chk(h, 16'h1234);
      t_rst(16'h0037);
      hacc(32'h6480_0021, 1'b1, 2'h1, 16'h005C);
      chk({last_a, last_be, last_wd[15:8]}, {21'h20, 2'h2, 8'h5C});
      hacc(32'h6480_0021, 1'b0, 2'h1, 16'h0);
      chk(h, 16'h005C);
      t_rst(16'h0034);
      saw_req <= 1'b0;
      hacc(32'h6480_0010, 1'b0, 2'h3, 16'h0);
      chk({saw_req, h}, {1'b0, 16'hDEAD});
   endtask

   task automatic end_sim;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // Time zero values, then the scenarios in turn
   initial
   begin
      {clk, rstn, cpu_ale, mem_ack, saw_req} = 5'h0;
      {we0_n, we1_n, rd0_n, rd1_n, slot_sel_n, cfg_sel_n} = 6'h3F;
      {cpu_ad, host_data_in, mem_rdata, config_strap_pins} = {26'h0, 16'h0, 16'h0F0F, 16'h0036};
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = {16'h0, 32'h0, 4'hF};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
      {dly, ack_dly, n_cyc, n_fail, check_count} = {32'd0, 32'd1, 96'd0};
      t_rst(16'h0036);
      t_regs();
      t_buf();
      t_modes();
      end_sim();
   end
endmodule // tb

`default_nettype wire
